// file: logic/fcs_pkg.sv
// Purpose: shared constants, decode function and state type of the flash command front end
// Assumes: 32-bit AXI4-Lite register bus, 17-bit byte address space
// Notes:   array words are 32 bits; the command engine programs 16-bit halves and erases whole words
package fcs_pkg;
    // address map
    localparam int          ADDR_W        = 17;
    localparam logic [16:0] REG_BASE      = 17'h1f000;
    localparam logic [11:0] OFS_STATUS    = 12'h000;
    localparam logic [11:0] OFS_CMD_INDEX = 12'h004;
    localparam logic [11:0] OFS_CMD_DATA  = 12'h008;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h00c;
    localparam logic [11:0] OFS_IRQ_MASK  = 12'h010;
    // storage sizes in bytes and 32-bit words
    localparam int          PROG_BYTES    = 32768;
    localparam int          EE_BYTES      = 1024;
    localparam int          MEM_WORDS     = (PROG_BYTES + EE_BYTES) / 4;
    localparam int          IDX_W         = 14;
    localparam logic [13:0] EE_FIRST_IDX  = 14'h2000;
    localparam logic [13:0] CFG_IDX       = 14'h1fff;
    localparam logic [13:0] SECTOR_MASK   = 14'h007f;
    localparam logic [7:0]  SECTOR_LAST   = 8'h7f;
    // status register fields
    localparam int          ST_COMMAND_COMPLETE_FLAG_BIT   = 7;
    localparam int          ST_BUSY_BIT   = 3;
    localparam int          ST_RESERVED_BIT_BIT   = 2;
    localparam logic [1:0]  ERR_NONE      = 2'h0;
    localparam logic [1:0]  ERR_ACCESS    = 2'h1;
    localparam logic [1:0]  ERR_VERIFY    = 2'h2;
    localparam logic [1:0]  ERR_INIT      = 2'h3;
    // interrupt status bits
    localparam int          IRQ_DONE_BIT  = 0;
    localparam int          IRQ_ERR_BIT   = 1;
    // command object
    localparam int          OBJ_WORDS     = 6;
    localparam logic [7:0]  CMD_PROGRAM   = 8'h06;
    localparam logic [7:0]  CMD_ERASE_SEC = 8'h0a;
    localparam logic [15:0] ERASED_HALF   = 16'hffff;
    localparam logic [31:0] ERASED_WORD   = 32'hffffffff;
    // reset-time initialisation
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          INIT_NS       = 100;
    localparam int          INIT_CYCLES   = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // bus answers
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        ENG_INIT, ENG_IDLE, ENG_CHECK, ENG_ERASE, ENG_DONE
    } fcs_eng_e;

    // map a byte address onto a storage word: {valid, index}
    function automatic logic [14:0] fcs_mem_index(input logic [16:0] addr);
        logic [14:0] r;
        r = 15'h0000;
        if (addr[16:15] == 2'h0) begin
            r = {1'b1, 1'b0, addr[14:2]};
        end else if (addr[16] && addr[15:10] == 6'h00) begin
            r = {1'b1, EE_FIRST_IDX | {6'h00, addr[9:2]}};
        end
        return r;
    endfunction
endpackage

// file: logic/fcs_cmd_if.sv
// Purpose: carrier between register front end and command engine
// Assumes: single clock domain
// Notes:   front end owns the storage array; engine owns busy, error and writes
`timescale 1ns/100ps
interface fcs_cmd_if;
    logic        launch;
    logic [7:0]  code;
    logic [16:0] gaddr;
    logic [15:0] data;
    logic        busy;
    logic        done;
    logic [1:0]  err;
    logic        mem_we;
    logic [1:0]  mem_hwe;
    logic [13:0] mem_idx;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;

    modport front (output launch, output code, output gaddr, output data,
                   input busy, input done, input err, input mem_we, input mem_hwe,
                   input mem_idx, input mem_wdata, output mem_rdata);
    modport engine (input launch, input code, input gaddr, input data,
                    output busy, output done, output err, output mem_we, output mem_hwe,
                    output mem_idx, output mem_wdata, input mem_rdata);
endinterface

// file: logic/fcs_engine.sv
// Purpose: memory controller sequencer: reset initialisation, program and sector erase
// Assumes: launch is a one-cycle pulse only given while busy is low
// Notes:   errors are held until the next launch
`timescale 1ns/100ps
module fcs_engine (
    input  wire logic CORE_CLK,
    input  wire logic SRST,
    fcs_cmd_if.engine cmd
);
    import fcs_pkg::*;

    fcs_eng_e    state;
    logic [7:0]  cnt;
    logic [14:0] dec;
    logic [15:0] cur_half;

    assign dec      = fcs_mem_index(cmd.gaddr);
    assign cur_half = cmd.gaddr[1] ? cmd.mem_rdata[31:16] : cmd.mem_rdata[15:0];

    // sequencer
    always_ff @(posedge CORE_CLK) begin
        cmd.done   <= 1'b0;
        cmd.mem_we <= 1'b0;
        if (SRST) begin
            state         <= ENG_INIT;
            cnt           <= 8'(INIT_CYCLES);
            cmd.busy      <= 1'b1;
            cmd.err       <= ERR_NONE;
            cmd.mem_idx   <= CFG_IDX;
            cmd.mem_hwe   <= 2'h0;
            cmd.mem_wdata <= ERASED_WORD;
        end else begin
            unique case (state)
                ENG_INIT: begin
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h00) begin
                        if (cmd.mem_rdata == 32'h00000000) begin
                            cmd.err <= ERR_INIT;
                        end
                        cmd.busy <= 1'b0;
                        state    <= ENG_IDLE;
                    end
                end
                ENG_IDLE: begin
                    if (cmd.launch) begin
                        cmd.busy    <= 1'b1;
                        cmd.err     <= ERR_NONE;
                        cmd.mem_idx <= dec[13:0];
                        if (cmd.code == CMD_PROGRAM && dec[14]) begin
                            state <= ENG_CHECK;
                        end else if (cmd.code == CMD_ERASE_SEC && dec[14]) begin
                            cmd.mem_idx <= dec[13:0] & ~SECTOR_MASK;
                            cnt         <= SECTOR_LAST;
                            state       <= ENG_ERASE;
                        end else begin
                            cmd.err <= ERR_ACCESS;
                            state   <= ENG_DONE;
                        end
                    end
                end
                ENG_CHECK: begin
                    if (cur_half == ERASED_HALF) begin
                        cmd.mem_we    <= 1'b1;
                        cmd.mem_hwe   <= cmd.gaddr[1] ? 2'h2 : 2'h1;
                        cmd.mem_wdata <= {cmd.data, cmd.data};
                    end else begin
                        cmd.err <= ERR_VERIFY;
                    end
                    state <= ENG_DONE;
                end
                ENG_ERASE: begin
                    cmd.mem_we    <= 1'b1;
                    cmd.mem_hwe   <= 2'h3;
                    cmd.mem_wdata <= ERASED_WORD;
                    if (cmd.mem_we) begin
                        cmd.mem_idx <= cmd.mem_idx + 14'h0001;
                        cnt         <= cnt - 8'h01;
                        if (cnt == 8'h00) begin
                            cmd.mem_we <= 1'b0;
                            state      <= ENG_DONE;
                        end
                    end
                end
                ENG_DONE: begin
                    cmd.done <= 1'b1;
                    cmd.busy <= 1'b0;
                    state    <= ENG_IDLE;
                end
            endcase
        end
    end
endmodule

// file: logic/flash_command_status.sv
// Purpose: AXI4-Lite front end of the on-chip program array and data EEPROM
// Assumes: CORE_CLK 250 MHz, SRST synchronous active high, one write and one read at a time
// Notes:   array contents change only through the command engine; bus writes to it fail
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

module flash_command_status (
    input  wire logic                     CORE_CLK,
    input  wire logic                     SRST,
    input  wire logic [fcs_pkg::ADDR_W-1:0] AWADDR,
    input  wire logic                     AWVALID,
    output logic                          AWREADY,
    input  wire logic [31:0]              WDATA,
    input  wire logic [3:0]               WSTRB,
    input  wire logic                     WVALID,
    output logic                          WREADY,
    output logic [1:0]                    BRESP,
    output logic                          BVALID,
    input  wire logic                     BREADY,
    input  wire logic [fcs_pkg::ADDR_W-1:0] ARADDR,
    input  wire logic                     ARVALID,
    output logic                          ARREADY,
    output logic [31:0]                   RDATA,
    output logic [1:0]                    RRESP,
    output logic                          RVALID,
    input  wire logic                     RREADY,
    output logic                          IRQ
);
    import fcs_pkg::*;

    fcs_cmd_if cmd ();

    // storage array, one 32-bit word per entry
    logic [31:0] mem [0:MEM_WORDS-1];

    // write channel holding state
    logic [16:0] aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;

    // software-visible registers
    logic [15:0] obj [0:OBJ_WORDS-1];
    logic [2:0]  obj_index;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        launch_q;

    // decode wires
    logic        do_write;
    logic        w_is_reg;
    logic [11:0] w_ofs;
    logic        w_status;
    logic        w_index;
    logic        w_data_sel;
    logic        w_istat;
    logic        w_imask;
    logic        w_mapped;
    logic        busy_any;
    logic        obj_refused;
    logic        launch_req;
    logic [15:0] obj_merged;
    logic        do_read;
    logic        r_is_reg;
    logic [11:0] r_ofs;
    logic [14:0] r_mem;
    logic [7:0]  status_val;
    logic [31:0] reg_rdata;
    logic        reg_rmapped;
    logic [1:0]  next_irq_stat;
    logic        err_event;

    // array initially erased
    initial begin
        for (int i = 0; i < MEM_WORDS; i++) begin
            mem[i] = ERASED_WORD;
        end
    end

    // write decode
    assign do_write    = aw_held && w_held && !BVALID;
    assign w_is_reg    = (aw_addr[16:12] == REG_BASE[16:12]);
    assign w_ofs       = {aw_addr[11:2], 2'b00};
    assign w_status    = w_is_reg && w_ofs == OFS_STATUS;
    assign w_index     = w_is_reg && w_ofs == OFS_CMD_INDEX;
    assign w_data_sel  = w_is_reg && w_ofs == OFS_CMD_DATA;
    assign w_istat     = w_is_reg && w_ofs == OFS_IRQ_STAT;
    assign w_imask     = w_is_reg && w_ofs == OFS_IRQ_MASK;
    assign w_mapped    = w_status || w_index || w_data_sel || w_istat || w_imask;
    assign busy_any    = cmd.busy || launch_q;
    assign obj_refused = busy_any && (w_index || w_data_sel || w_status);
    assign launch_req  = do_write && w_status && w_strb[0] && w_data[ST_COMMAND_COMPLETE_FLAG_BIT] && !busy_any;
    assign obj_merged  = {w_strb[1] ? w_data[15:8] : obj[obj_index][15:8],
                          w_strb[0] ? w_data[7:0]  : obj[obj_index][7:0]};

    // command object feeds the engine
    assign cmd.launch = launch_q;
    assign cmd.code   = obj[0][15:8];
    assign cmd.gaddr  = {obj[0][0], obj[1]};
    assign cmd.data   = obj[2];
    // engine read port into the array
    assign cmd.mem_rdata = mem[cmd.mem_idx];

    // read decode
    assign do_read   = ARVALID && !RVALID;
    assign r_is_reg  = (ARADDR[16:12] == REG_BASE[16:12]);
    assign r_ofs     = {ARADDR[11:2], 2'b00};
    assign r_mem     = fcs_mem_index(ARADDR);
    // busy mirrors complete flag; reserved bit zero
    assign status_val = {~busy_any, 3'b000, busy_any, 1'b0, cmd.err};
    assign reg_rmapped = r_is_reg && (r_ofs == OFS_STATUS || r_ofs == OFS_CMD_INDEX
                         || r_ofs == OFS_CMD_DATA || r_ofs == OFS_IRQ_STAT
                         || r_ofs == OFS_IRQ_MASK);
    assign reg_rdata = (r_ofs == OFS_STATUS)    ? {24'h000000, status_val} :
                       (r_ofs == OFS_CMD_INDEX) ? {29'h00000000, obj_index} :
                       (r_ofs == OFS_CMD_DATA && obj_index < 3'(OBJ_WORDS))
                                                ? {16'h0000, obj[obj_index]} :
                       (r_ofs == OFS_IRQ_STAT)  ? {30'h00000000, irq_stat} :
                       (r_ofs == OFS_IRQ_MASK)  ? {30'h00000000, irq_mask} : 32'h00000000;

    // interrupt events: set wins over write-one-to-clear
    assign err_event     = cmd.done && (cmd.err != ERR_NONE);
    assign next_irq_stat = ((do_write && w_istat && w_strb[0]) ? (irq_stat & ~w_data[1:0])
                            : irq_stat) | {err_event, cmd.done};

    // write address and data capture, either order
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 17'h00000;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
        end else begin
            AWREADY <= !aw_held && !(AWVALID && AWREADY);
            WREADY  <= !w_held && !(WVALID && WREADY);
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response: array and unmapped space refuse, busy refuses object and status writes
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            BVALID <= 1'b0;
            BRESP  <= RESP_OKAY;
        end else if (do_write) begin
            BVALID <= 1'b1;
            BRESP  <= (w_mapped && !obj_refused) ? RESP_OKAY : RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            obj_index <= 3'h0;
            for (int i = 0; i < OBJ_WORDS; i++) begin
                obj[i] <= 16'h0000;
            end
        end else if (do_write && !obj_refused) begin
            if (w_index && w_strb[0]) begin
                obj_index <= w_data[2:0];
            end
            if (w_data_sel && obj_index < 3'(OBJ_WORDS)) begin
                obj[obj_index] <= obj_merged;
            end
        end
    end

    // launch pulse, mask and interrupt status
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            launch_q <= 1'b0;
            irq_mask <= 2'h0;
            irq_stat <= 2'h0;
            IRQ      <= 1'b0;
        end else begin
            launch_q <= launch_req;
            irq_stat <= next_irq_stat;
            IRQ      <= |(next_irq_stat & irq_mask);
            if (do_write && w_imask && w_strb[0]) begin
                irq_mask <= w_data[1:0];
            end
        end
    end

    // one-cycle read answer; array data as stored
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b0;
            RDATA   <= 32'h00000000;
            RRESP   <= RESP_OKAY;
        end else begin
            ARREADY <= !RVALID && !(ARVALID && ARREADY);
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                if (r_mem[14]) begin
                    RDATA <= mem[r_mem[13:0]];
                    RRESP <= RESP_OKAY;
                end else begin
                    RDATA <= reg_rmapped ? reg_rdata : 32'h00000000; // unmapped reads zero
                    RRESP <= reg_rmapped ? RESP_OKAY : RESP_SLVERR;
                end
            end else if (RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    // array changed only by the engine
    always_ff @(posedge CORE_CLK) begin
        if (cmd.mem_we) begin
            if (cmd.mem_hwe[0]) begin
                mem[cmd.mem_idx][15:0] <= cmd.mem_wdata[15:0];
            end
            if (cmd.mem_hwe[1]) begin
                mem[cmd.mem_idx][31:16] <= cmd.mem_wdata[31:16];
            end
        end
    end

    fcs_engine u_engine (
        .CORE_CLK (CORE_CLK),
        .SRST     (SRST),
        .cmd      (cmd)
    );
endmodule

// file: testbench/fcs_host_model.sv
// Purpose: register bus master standing in for the host processor
// Assumes: one write and one read at a time, waits bounded by the bench
// Notes:   a released payload shows the inverse of the value given to the task
`timescale 1ns/100ps
module fcs_host_model (
    input  wire logic                       CORE_CLK,
    output logic [fcs_pkg::ADDR_W-1:0]      AWADDR,
    output logic                            AWVALID,
    input  wire logic                       AWREADY,
    output logic [31:0]                     WDATA,
    output logic [3:0]                      WSTRB,
    output logic                            WVALID,
    input  wire logic                       WREADY,
    input  wire logic [1:0]                 BRESP,
    input  wire logic                       BVALID,
    output logic                            BREADY,
    output logic [fcs_pkg::ADDR_W-1:0]      ARADDR,
    output logic                            ARVALID,
    input  wire logic                       ARREADY,
    input  wire logic [31:0]                RDATA,
    input  wire logic [1:0]                 RRESP,
    input  wire logic                       RVALID,
    output logic                            RREADY
);
    import fcs_pkg::*;
    logic [3:0] strb = 4'hf; // write lanes, set by the bench
    // all requests idle from time zero
    initial begin
        {AWADDR, AWVALID, WDATA, WSTRB, WVALID, BREADY} = '0;
        {ARADDR, ARVALID, RREADY} = '0;
    end
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [16:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge CORE_CLK);
        AWADDR  <= a;
        AWVALID <= 1'b1;
        WDATA   <= d;
        WSTRB   <= strb;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (AWVALID && AWREADY) begin
                AWVALID <= 1'b0;
                AWADDR  <= ~a;
            end
            if (WVALID && WREADY) begin
                WVALID <= 1'b0;
                WDATA  <= ~d;
            end
        end while (BVALID !== 1'b1);
        r = BRESP;
        BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [16:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CORE_CLK);
        ARADDR  <= {a[16:2], 2'h0};
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (ARVALID && ARREADY) begin
                ARVALID <= 1'b0;
                ARADDR  <= ~a;
            end
        end while (RVALID !== 1'b1);
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask
    // poll status until the complete flag reads one, giving up after 500 reads
    task automatic wait_idle(output logic [31:0] v);
        logic [1:0] r;
        int         n;
        n = 0;
        do begin
            rd(REG_BASE | {5'h00, OFS_STATUS}, v, r);
            n++;
        end while (v[ST_COMMAND_COMPLETE_FLAG_BIT] !== 1'b1 && n < 500);
    endtask
    // load the command object and launch it
    task automatic run_cmd(input logic [7:0] c, input logic [16:0] a, input logic [15:0] d);
        logic [31:0] v;
        logic [1:0]  r;
        wait_idle(v);
        wr(REG_BASE | {5'h00, OFS_CMD_INDEX}, 32'h0, r);
        wr(REG_BASE | {5'h00, OFS_CMD_DATA}, {16'h0, c, 7'h0, a[16]}, r);
        wr(REG_BASE | {5'h00, OFS_CMD_INDEX}, 32'h1, r);
        wr(REG_BASE | {5'h00, OFS_CMD_DATA}, {16'h0, a[15:0]}, r);
        wr(REG_BASE | {5'h00, OFS_CMD_INDEX}, 32'h2, r);
        wr(REG_BASE | {5'h00, OFS_CMD_DATA}, {16'h0, d}, r);
        wr(REG_BASE | {5'h00, OFS_STATUS}, 32'h80, r);
    endtask
endmodule

// file: testbench/fcs_checker_sva.sv
// Purpose: concurrent checks on bus answers and status reads
// Assumes: one clock, SRST synchronous active high
// Notes:   sees the top module ports only
`timescale 1ns/100ps
module fcs_checker (
    input  wire logic                  CORE_CLK,
    input  wire logic                  SRST,
    input  wire logic [fcs_pkg::ADDR_W-1:0] AWADDR,
    input  wire logic                  AWVALID,
    input  wire logic                  AWREADY,
    input  wire logic [1:0]            BRESP,
    input  wire logic                  BVALID,
    input  wire logic                  BREADY,
    input  wire logic [fcs_pkg::ADDR_W-1:0] ARADDR,
    input  wire logic                  ARVALID,
    input  wire logic                  ARREADY,
    input  wire logic [31:0]           RDATA,
    input  wire logic [1:0]            RRESP,
    input  wire logic                  RVALID,
    input  wire logic                  RREADY,
    input  wire logic                  IRQ
);
    import fcs_pkg::*;
    // taken reads of status and program array, taken writes to the program array
    wire rd_st  = ARVALID && ARREADY && ARADDR == (REG_BASE | {5'h00, OFS_STATUS});
    wire rd_arr = ARVALID && ARREADY && ARADDR < 17'h08000;
    wire wr_arr = AWVALID && AWREADY && AWADDR < 17'h08000;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    a_reset_quiet: assert property ($past(SRST) |->
        !AWREADY && !ARREADY && !BVALID && !RVALID && !IRQ) else $error("bus busy after reset");
    a_read_one_cycle: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    a_rdata_stands: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer dropped");
    a_bresp_stands: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped");
    a_ar_refused: assert property (RVALID |-> !ARREADY) else $error("read taken while pending");
    a_reserved_bit_zero: assert property (rd_st |=> !RDATA[ST_RESERVED_BIT_BIT])
        else $error("reserved status bit set");
    a_busy_mirror: assert property (rd_st |=> RDATA[ST_BUSY_BIT] != RDATA[ST_COMMAND_COMPLETE_FLAG_BIT])
        else $error("busy and complete disagree");
    a_array_ro: assert property (wr_arr |-> ##[1:4] BVALID && BRESP == RESP_SLVERR)
        else $error("array write accepted");
    a_array_okay: assert property (rd_arr |=> RRESP == RESP_OKAY)
        else $error("array read refused");
    a_unmapped_read: assert property (ARVALID && ARREADY && ARADDR[16:12] == 5'h18
        |=> RRESP == RESP_SLVERR && RDATA == 32'h0) else $error("unmapped read answered");
    cover property (BVALID && BRESP == RESP_SLVERR);
    cover property (IRQ);
    cover property (rd_st ##1 RDATA[ST_BUSY_BIT]);
endmodule
bind flash_command_status fcs_checker u_chk (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ));

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the flash command front end
// Assumes: CORE_CLK 4 ns, SRST synchronous active high
// Notes:   random addresses and data come from a fixed-seed xorshift
`timescale 1ns/100ps
module tb_top;
    import fcs_pkg::*;
    logic        CORE_CLK = 1'b0;
    logic        SRST     = 1'b1;
    logic [16:0] AWADDR, ARADDR, a;
    logic [31:0] WDATA, RDATA, v, s, w;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP, r;
    logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic        ARVALID, ARREADY, RVALID, RREADY, IRQ;
    logic [15:0] d;
    logic [31:0] seed = 32'h00010079;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #2 CORE_CLK = ~CORE_CLK;

    flash_command_status DUT (.CORE_CLK(CORE_CLK), .SRST(SRST), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .IRQ(IRQ));
    fcs_host_model host (.CORE_CLK(CORE_CLK), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

    // xorshift source and expected values
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [16:0] ra(input logic [11:0] o);
        return REG_BASE | {5'h00, o};
    endfunction
    function automatic logic [31:0] prog(input logic [31:0] o, input logic ad1,
                                         input logic [15:0] dd);
        return ad1 ? {dd, o[15:0]} : {o[31:16], dd};
    endfunction
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // main sequence
    initial begin
        repeat (2) @(posedge CORE_CLK);
        SRST <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        host.rd(ra(OFS_STATUS), v, r);
        chk(v, 32'h08);
        host.wr(ra(OFS_CMD_DATA), 32'h1234, r);
        chk(r, RESP_SLVERR);
        host.wait_idle(v);
        chk(v, 32'h80);
        for (int i = 0; i < 16; i++) begin
            w = rnd();
            a = i[0] ? {7'h40, w[9:0]} : {2'h0, w[14:0]};
            host.rd(a, v, r);
            chk(v, ERASED_WORD);
        end
        host.wr(a, 32'h0, r);
        chk(r, RESP_SLVERR);
        host.wr({2'h0, w[14:0]}, 32'h0, r);
        chk(r, RESP_SLVERR);
        host.rd(17'h18000, v, r);
        chk(r, RESP_SLVERR);
        chk(v, 32'h00000000);
        host.wr(ra(OFS_IRQ_MASK), 32'h3, r);
        // upper lane only merges into an unused object word
        host.wr(ra(OFS_CMD_INDEX), 32'h3, r);
        host.strb = 4'h2;
        host.wr(ra(OFS_CMD_DATA), 32'hbeef, r);
        host.strb = 4'hf;
        host.rd(ra(OFS_CMD_DATA), v, r);
        chk(v, 32'hbe00);
        for (int i = 0; i < 6; i++) begin
            w = rnd();
            a = i[0] ? {7'h40, w[9:1], 1'b0} : {3'h0, w[13:1], 1'b0};
            d = w[31:16];
            host.rd(a, v, r);
            host.run_cmd(CMD_PROGRAM, a, d);
            host.wait_idle(s);
            chk(s, 32'h80);
            host.rd(a, s, r);
            chk(s, prog(v, a[1], d));
            host.rd(ra(OFS_IRQ_STAT), s, r);
            chk(s, 32'h1);
            chk(IRQ, 1'b1);
            host.wr(ra(OFS_IRQ_STAT), 32'h3, r);
            host.rd(ra(OFS_IRQ_STAT), s, r);
            chk(IRQ, 1'b0);
        end
        // deliberate second program of one half
        host.run_cmd(CMD_PROGRAM, a, ~d);
        host.wait_idle(s);
        chk(s, {30'h20, ERR_VERIFY});
        host.rd(ra(OFS_IRQ_STAT), s, r);
        chk(s, 32'h3);
        host.wr(ra(OFS_IRQ_MASK), 32'h0, r);
        host.rd(ra(OFS_IRQ_STAT), s, r);
        chk(IRQ, 1'b0);
        host.wr(ra(OFS_IRQ_STAT), 32'h3, r);
        host.run_cmd(CMD_ERASE_SEC, a, 16'h0);
        host.rd(ra(OFS_STATUS), s, r);
        chk(s, 32'h08);
        host.wr(ra(OFS_CMD_INDEX), 32'h0, r);
        chk(r, RESP_SLVERR);
        host.wait_idle(s);
        chk(s, 32'h80);
        host.rd(a, s, r);
        chk(s, ERASED_WORD);
        host.run_cmd(8'hff, a, 16'h0);
        host.wait_idle(s);
        chk(s, {30'h20, ERR_ACCESS});
        host.run_cmd(CMD_PROGRAM, 17'h07ffc, 16'h0);
        host.run_cmd(CMD_PROGRAM, 17'h07ffe, 16'h0);
        host.wait_idle(s);
        // second reset with an all-zero marker word
        SRST <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        SRST <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        host.wait_idle(s);
        chk(s, {30'h20, ERR_INIT});
        close_out();
    end
endmodule
